/* File: rtl/ssc_defs.svh */
/*
  constants for the single-sweep capture block: record size, field widths,
  channel limit and record end addresses.
  assumes it is included by bare name from the package and the capture module.
*/
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH
`define SSC_RECORD_POINTS 512
`define SSC_ADDR_W 9
`define SSC_SAMPLE_W 10
`define SSC_MAX_RT_CHANNELS 2
`define SSC_LAST_ADDR 9'h1ff
`define SSC_ZERO_ADDR 9'h000
`define SSC_RT_CNT_W 3
`endif

/* File: rtl/ssc_pkg.sv */
/*
  types shared by the capture controller and its padding writer.
  assumes ssc_defs.svh is on the include path.
*/
`include "ssc_defs.svh"
package ssc_pkg;
  typedef logic [`SSC_ADDR_W-1:0] ssc_addr_t;
  typedef logic [`SSC_SAMPLE_W-1:0] ssc_sample_t;

  typedef enum logic [2:0] {
    SSC_IDLE,
    SSC_WAIT_TRIG,
    SSC_SAMPLE,
    SSC_PAD,
    SSC_DONE
  } ssc_state_t;

  // one waveform memory write
  typedef struct packed {
    logic we;
    ssc_addr_t addr;
    ssc_sample_t data;
  } ssc_wr_t;

  // display and time-base configuration checked before a capture starts
  typedef struct packed {
    logic [`SSC_RT_CNT_W-1:0] rt_channels;
    logic chop_active;
    logic slot_has_acq_tb;
    logic slot_selected;
  } ssc_cfg_t;

  // state of the pad writer
  typedef struct packed {
    logic busy;
    ssc_addr_t addr;
    ssc_addr_t stop;
    ssc_sample_t value;
    ssc_wr_t wr;
  } ssc_pad_state_t;
endpackage

/* File: rtl/ssc_pad_writer.sv */
/*
  pad writer: fills a run of waveform memory addresses with one value,
  from first_i upward up to and including stop_i, one word per cycle.
  assumes a start pulse only while busy_o is low; same clock as the caller.
*/
`timescale 1ns/1ps
module ssc_pad_writer (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire ssc_pkg::ssc_addr_t first_i,
  input wire ssc_pkg::ssc_addr_t stop_i,
  input wire ssc_pkg::ssc_sample_t value_i,
  output ssc_pkg::ssc_wr_t wr_o,
  output logic busy_o
);
  ssc_pkg::ssc_pad_state_t s_q, s_d;

  // one write per cycle until the stop address has been written
  always_comb begin
    s_d = s_q;
    s_d.wr.we = 1'b0;
    if (start_i && !s_q.busy) begin
      s_d.busy = 1'b1;
      s_d.addr = first_i;
      s_d.stop = stop_i;
      s_d.value = value_i;
    end else if (s_q.busy) begin
      s_d.wr.we = 1'b1;
      s_d.wr.addr = s_q.addr;
      s_d.wr.data = s_q.value;
      s_d.addr = s_q.addr + `SSC_ADDR_W'(1);
      if (s_q.addr == s_q.stop) begin
        s_d.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wr_o = s_q.wr;
  assign busy_o = s_q.busy;
endmodule

/* File: rtl/ssc_capture.sv */
/*
  single-sweep capture controller: waits for the one-shot trigger, then
  stores one sample per rising acquire clock edge into 512 record positions,
  with early end only by the abort input and padding of short records.
  assumes trigger, acquire clock and abort are asynchronous pins (two-flop
  synchronised here, acquire clock must be well below core_clk_i/2);
  command, config and zero level come from logic on core_clk_i.
*/
// Operation
// - store 512 samples in order, successive addresses
// - only the abort input ends capture early
// - refuse other commands while busy, show busy
// - busy also covers waiting for the trigger
// - partial capture right-justified in the record
// - unfilled positions take the earliest sample value
// - no samples: fill with vertical zero level
// - over two channels or chop: capture error
// - zero level is the measured ground mean
`timescale 1ns/1ps
`include "ssc_defs.svh"
module ssc_capture (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic single_sweep_capture_cmd_i,
  input wire logic other_cmd_i,
  input wire logic capture_abort_input_i,
  input wire logic trigger_i,
  input wire logic acquire_clk_i,
  input wire ssc_pkg::ssc_sample_t sample_i,
  input wire ssc_pkg::ssc_cfg_t cfg_i,
  input wire ssc_pkg::ssc_sample_t vertical_zero_level_i,
  output logic busy_o,
  output logic cmd_reject_o,
  output logic capture_error_flag_o,
  output logic capture_done_o,
  output ssc_pkg::ssc_wr_t wr_o
);
  typedef struct packed {
    logic [1:0] abort_s;
    logic [1:0] trig_s;
    logic [2:0] acq_s;
    ssc_pkg::ssc_sample_t smp_s0;
    ssc_pkg::ssc_sample_t smp_s1;
    ssc_pkg::ssc_state_t st;
    logic [`SSC_ADDR_W:0] count;
    ssc_pkg::ssc_sample_t first;
    ssc_pkg::ssc_addr_t shift;
    logic mv;
    ssc_pkg::ssc_addr_t mv_idx;
    // local copy of the taken samples, needed to re-lay a short record
    ssc_pkg::ssc_sample_t [`SSC_RECORD_POINTS-1:0] rec;
    logic pad_go;
    ssc_pkg::ssc_addr_t pad_first;
    ssc_pkg::ssc_addr_t pad_stop;
    ssc_pkg::ssc_sample_t pad_val;
    logic busy;
    logic reject;
    logic err;
    logic done;
    ssc_pkg::ssc_wr_t wr;
  } ssc_cap_state_t;

  ssc_cap_state_t s_q, s_d;
  ssc_pkg::ssc_wr_t pad_wr;
  logic pad_busy;
  logic [`SSC_ADDR_W:0] last_count;
  logic acq_edge;
  logic cfg_ok;

  assign last_count = (`SSC_ADDR_W+1)'(`SSC_RECORD_POINTS);
  // rising edge seen only on synchronised stages, never the first flop
  assign acq_edge = s_q.acq_s[1] && !s_q.acq_s[2];
  // channel count, chop and time-base checks
  assign cfg_ok = (cfg_i.rt_channels <= `SSC_RT_CNT_W'(`SSC_MAX_RT_CHANNELS))
    && !cfg_i.chop_active
    && cfg_i.slot_has_acq_tb && cfg_i.slot_selected;

  ssc_pad_writer u_pad (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .start_i(s_q.pad_go),
    .first_i(s_q.pad_first),
    .stop_i(s_q.pad_stop),
    .value_i(s_q.pad_val),
    .wr_o(pad_wr),
    .busy_o(pad_busy)
  );

  // next state of the whole controller
  always_comb begin
    s_d = s_q;
    s_d.abort_s = {s_q.abort_s[0], capture_abort_input_i};
    s_d.trig_s = {s_q.trig_s[0], trigger_i};
    s_d.acq_s = {s_q.acq_s[1:0], acquire_clk_i};
    // sample bus is registered twice; acquire edge delay matches it
    s_d.smp_s0 = sample_i;
    s_d.smp_s1 = s_q.smp_s0;
    s_d.pad_go = 1'b0;
    s_d.reject = 1'b0;
    s_d.done = 1'b0;
    s_d.wr = pad_wr;
    unique case (s_q.st)
      ssc_pkg::SSC_IDLE: begin
        if (single_sweep_capture_cmd_i) begin
          if (cfg_ok) begin
            s_d.st = ssc_pkg::SSC_WAIT_TRIG;
            s_d.busy = 1'b1;
            s_d.err = 1'b0;
            s_d.count = '0;
          end else begin
            s_d.err = 1'b1;
          end
        end
      end
      ssc_pkg::SSC_WAIT_TRIG: begin
        s_d.reject = other_cmd_i || single_sweep_capture_cmd_i;
        if (s_q.abort_s[1]) begin
          // nothing sampled: whole record at the zero level
          s_d.st = ssc_pkg::SSC_PAD;
          s_d.pad_go = 1'b1;
          s_d.pad_first = `SSC_ZERO_ADDR;
          s_d.pad_stop = `SSC_LAST_ADDR;
          s_d.pad_val = vertical_zero_level_i;
        end else if (s_q.trig_s[1]) begin
          s_d.st = ssc_pkg::SSC_SAMPLE;
        end
      end
      ssc_pkg::SSC_SAMPLE: begin
        s_d.reject = other_cmd_i || single_sweep_capture_cmd_i;
        if (s_q.abort_s[1]) begin
          if (s_q.count == '0) begin
            s_d.st = ssc_pkg::SSC_PAD;
            s_d.pad_go = 1'b1;
            s_d.pad_first = `SSC_ZERO_ADDR;
            s_d.pad_stop = `SSC_LAST_ADDR;
            s_d.pad_val = vertical_zero_level_i;
          end else begin
            // the record cannot be read back, so the kept samples are
            // replayed from the local copy to the right end first, then
            // the head is padded; costs n extra cycles after the abort
            s_d.st = ssc_pkg::SSC_PAD;
            s_d.mv = 1'b1;
            s_d.mv_idx = `SSC_ZERO_ADDR;
            s_d.pad_first = `SSC_ZERO_ADDR;
            s_d.pad_stop = s_q.shift - `SSC_ADDR_W'(1);
            s_d.pad_val = s_q.first;
          end
        end else if (acq_edge) begin
          // sample n goes to address n and into the local copy; shift
          // keeps where the earliest sample lands if an abort follows
          s_d.wr.we = 1'b1;
          s_d.wr.addr = `SSC_ADDR_W'(s_q.count);
          s_d.wr.data = s_q.smp_s1;
          s_d.rec[s_q.count[`SSC_ADDR_W-1:0]] = s_q.smp_s1;
          if (s_q.count == '0) begin
            s_d.first = s_q.smp_s1;
          end
          s_d.count = s_q.count + (`SSC_ADDR_W+1)'(1);
          s_d.shift = `SSC_LAST_ADDR - `SSC_ADDR_W'(s_q.count);
          if (s_d.count == last_count) begin
            s_d.st = ssc_pkg::SSC_DONE;
          end
        end
      end
      ssc_pkg::SSC_PAD: begin
        s_d.reject = other_cmd_i || single_sweep_capture_cmd_i;
        if (s_q.mv) begin
          // one kept sample per cycle, earliest at 512-n, latest at 511
          s_d.wr.we = 1'b1;
          s_d.wr.addr = s_q.shift;
          s_d.wr.data = s_q.rec[s_q.mv_idx];
          s_d.shift = s_q.shift + `SSC_ADDR_W'(1);
          s_d.mv_idx = s_q.mv_idx + `SSC_ADDR_W'(1);
          if (s_q.shift == `SSC_LAST_ADDR) begin
            s_d.mv = 1'b0;
            s_d.pad_go = 1'b1;
          end
        end else if (!s_q.pad_go && !pad_busy) begin
          s_d.st = ssc_pkg::SSC_DONE;
        end
      end
      ssc_pkg::SSC_DONE: begin
        s_d.reject = other_cmd_i || single_sweep_capture_cmd_i;
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.st = ssc_pkg::SSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_o = s_q.busy;
  assign cmd_reject_o = s_q.reject;
  assign capture_error_flag_o = s_q.err;
  assign capture_done_o = s_q.done;
  assign wr_o = s_q.wr;

  sequence s_trig_seen;
    s_q.st == ssc_pkg::SSC_WAIT_TRIG && s_q.trig_s[1] && !s_q.abort_s[1];
  endsequence

  AST_BUSY_WAIT: assert property (@(posedge core_clk_i) disable iff (srst_i)
    s_q.st == ssc_pkg::SSC_WAIT_TRIG |-> busy_o)
    else $error("busy low while waiting for trigger");
  AST_REJECT: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_q.st == ssc_pkg::SSC_SAMPLE && other_cmd_i) |=> cmd_reject_o)
    else $error("command not refused during capture");
  AST_CFG_ERR: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_q.st == ssc_pkg::SSC_IDLE && single_sweep_capture_cmd_i && cfg_i.chop_active)
    |=> capture_error_flag_o && !busy_o)
    else $error("chop mode accepted");
  AST_TB_ERR: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_q.st == ssc_pkg::SSC_IDLE && single_sweep_capture_cmd_i && !cfg_i.slot_selected)
    |=> capture_error_flag_o)
    else $error("missing time base accepted");
  AST_NO_EARLY_END: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_q.st == ssc_pkg::SSC_SAMPLE && !s_q.abort_s[1] && s_q.count < 10'h1ff)
    |=> s_q.st == ssc_pkg::SSC_SAMPLE)
    else $error("capture ended without abort");
  AST_TRIG_START: assert property (@(posedge core_clk_i) disable iff (srst_i)
    s_trig_seen |=> s_q.st == ssc_pkg::SSC_SAMPLE && s_q.count == '0)
    else $error("trigger did not start sampling");
  AST_ORDER: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_q.st == ssc_pkg::SSC_SAMPLE && acq_edge && !s_q.abort_s[1])
    |=> wr_o.we && wr_o.addr == $past(s_q.count[`SSC_ADDR_W-1:0]))
    else $error("sample not at next address");
  AST_ZERO_FILL: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_q.st == ssc_pkg::SSC_WAIT_TRIG && s_q.abort_s[1])
    |=> s_q.pad_go && s_q.pad_val == $past(vertical_zero_level_i))
    else $error("empty abort not zero filled");

  sequence s_move_step;
    s_q.st == ssc_pkg::SSC_PAD && s_q.mv;
  endsequence

  AST_MOVE_ADDR: assert property (@(posedge core_clk_i) disable iff (srst_i)
    s_move_step |=> wr_o.we && wr_o.addr == $past(s_q.shift)
      && wr_o.data == $past(s_q.rec[s_q.mv_idx]))
    else $error("kept sample not placed at the right end");
  AST_PAD_FIRST: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_q.st == ssc_pkg::SSC_SAMPLE && s_q.abort_s[1] && s_q.count != '0)
    |=> s_q.mv && s_q.pad_val == $past(s_q.first))
    else $error("padding not the earliest sample");
endmodule

/* File: verif/ssc_timebase_model.sv */
/*
  time-base model: one-shot trigger, then n acquire clock pulses with a
  fresh sample each. assumes fire_i is a one-cycle pulse on core_clk_i.
*/
`timescale 1ns/1ps
module ssc_timebase_model (
  input wire logic core_clk_i,
  input wire logic fire_i,
  input wire logic [9:0] n_pts_i,
  input wire logic desel_i,
  output logic trigger_o,
  output logic acq_clk_o,
  output ssc_pkg::ssc_sample_t sample_o,
  output logic slot_has_acq_tb_o,
  output logic slot_selected_o
);
  // slot holds an acquire time base, deselected only on request
  assign slot_has_acq_tb_o = 1'b1;
  assign slot_selected_o = ~desel_i;
  initial begin
    trigger_o = 1'b0;
    acq_clk_o = 1'b0;
    sample_o = 10'h3c3;
  end
  // acquire clock idles low between sweeps; sample held around each rise
  always @(posedge core_clk_i) begin
    if (fire_i) begin
      trigger_o <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      for (int k = 0; k < n_pts_i; k++) begin
        sample_o <= 10'(k * 3 + 5);
        repeat (3) @(posedge core_clk_i);
        acq_clk_o <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        acq_clk_o <= 1'b0;
        sample_o <= ~sample_o; // stale value is never left on the pins
        repeat (2) @(posedge core_clk_i);
      end
      trigger_o <= 1'b0;
    end
  end
endmodule

/* File: verif/ssc_capture_tb.sv */
/*
  self-checking bench for the capture controller with a time-base model.
  assumes the hand-over timing: pulsed commands, synchronised pins.
*/
`timescale 1ns/1ps
module ssc_capture_tb;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic cmd = 1'b0, oth = 1'b0, abort = 1'b0, fire = 1'b0, desel = 1'b0;
  logic chop = 1'b0;
  logic [2:0] rt = 3'h1;
  logic [9:0] npts = 10'h000;
  logic trig, aclk, has_tb, sel, busy, rej, err, done;
  ssc_pkg::ssc_sample_t smp;
  ssc_pkg::ssc_wr_t wr;
  ssc_pkg::ssc_sample_t mem [512];
  int wcnt = 0, errors = 0, tests_run = 0;
  localparam logic [9:0] ZERO_LVL = 10'h2a5;

  always #10 core_clk_i = ~core_clk_i;

  ssc_capture i_ssc_capture (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .single_sweep_capture_cmd_i(cmd), .other_cmd_i(oth), .capture_abort_input_i(abort),
    .trigger_i(trig), .acquire_clk_i(aclk), .sample_i(smp),
    .cfg_i(ssc_pkg::ssc_cfg_t'({rt, chop, has_tb, sel})), .vertical_zero_level_i(ZERO_LVL),
    .busy_o(busy), .cmd_reject_o(rej), .capture_error_flag_o(err),
    .capture_done_o(done), .wr_o(wr));

  ssc_timebase_model i_ssc_timebase_model (.core_clk_i(core_clk_i), .fire_i(fire),
    .n_pts_i(npts), .desel_i(desel), .trigger_o(trig), .acq_clk_o(aclk),
    .sample_o(smp), .slot_has_acq_tb_o(has_tb), .slot_selected_o(sel));

  // keep the whole record so it is judged after the capture ends
  always @(posedge core_clk_i) begin
    if (wr.we === 1'b1) begin
      mem[wr.addr] <= wr.data;
      wcnt <= wcnt + 1;
    end
  end

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chk_val(input ssc_pkg::ssc_sample_t got, input ssc_pkg::ssc_sample_t exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t value got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  localparam int P_CMD = 0;
  localparam int P_OTH = 1;
  localparam int P_FIRE = 2;

  // one-cycle strobe on the chosen input, raised and dropped on rising edges
  task automatic pulse(input int which);
    @(posedge core_clk_i);
    if (which == P_CMD) cmd <= 1'b1;
    else if (which == P_OTH) oth <= 1'b1;
    else fire <= 1'b1;
    @(posedge core_clk_i);
    cmd <= 1'b0;
    oth <= 1'b0;
    fire <= 1'b0;
  endtask

  // stale words would hide a missing write, so preset a foreign pattern
  task automatic clear_rec();
    for (int a = 0; a < 512; a++) mem[a] = 10'h3c3;
    wcnt = 0;
  endtask

  task automatic wait_done(input int lim);
    for (int i = 0; i < lim && done !== 1'b1; i++) tick(1);
    chk_bit(done, 1'b1);
    tick(2);
    chk_bit(busy, 1'b0);
  endtask

  // samples sit at the right end, the rest repeats the earliest one
  task automatic chk_rec(input int n);
    for (int a = 0; a < 512; a++) begin
      if (n == 0) chk_val(mem[a], ZERO_LVL);
      else if (a < 512 - n) chk_val(mem[a], 10'h005);
      else chk_val(mem[a], 10'((a - 512 + n) * 3 + 5));
    end
  endtask

  task automatic test_cfg_err();
    logic [4:0] bad [3] = '{5'b011_0_0, 5'b010_1_0, 5'b001_0_1};
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk_i) {rt, chop, desel} <= bad[i];
      pulse(P_CMD);
      tick(2);
      chk_bit(err, 1'b1);
      chk_bit(busy, 1'b0);
    end
    @(posedge core_clk_i) {rt, chop, desel} <= 5'b010_0_0;
    $display("test cfg_err done");
  endtask

  task automatic test_full();
    logic seen;
    clear_rec();
    pulse(P_CMD);
    tick(2);
    chk_bit(busy, 1'b1);
    chk_bit(err, 1'b0);
    pulse(P_OTH);
    // the refusal stands one cycle from the edge that ends the strobe
    tick(0);
    seen = rej;
    repeat (3) begin
      tick(1);
      seen |= rej;
    end
    chk_bit(seen, 1'b1);
    npts <= 10'h200;
    pulse(P_FIRE);
    tick(100);
    pulse(P_CMD);
    tick(3);
    chk_bit(busy, 1'b1);
    wait_done(6000);
    chk_rec(512);
    $display("test full done");
  endtask

  task automatic test_partial();
    clear_rec();
    pulse(P_CMD);
    npts <= 10'h005;
    pulse(P_FIRE);
    for (int i = 0; i < 200 && wcnt < 5; i++) tick(1);
    @(posedge core_clk_i) abort <= 1'b1;
    wait_done(1000);
    @(posedge core_clk_i) abort <= 1'b0;
    chk_rec(5);
    $display("test partial done");
  endtask

  task automatic test_zero();
    clear_rec();
    pulse(P_CMD);
    tick(5);
    chk_bit(busy, 1'b1);
    @(posedge core_clk_i) abort <= 1'b1;
    wait_done(1000);
    @(posedge core_clk_i) abort <= 1'b0;
    chk_rec(0);
    $display("test zero done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // a hung handshake ends the run through the same verdict
  initial begin
    repeat (20000) @(posedge core_clk_i);
    errors++;
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge core_clk_i);
    srst_i <= 1'b0;
    tick(1);
    test_cfg_err();
    test_full();
    test_partial();
    test_zero();
    give_verdict();
  end
endmodule
